// File: rtl/led_fault_supervisor.sv
// fault supervisor deciding boost, disconnect switch, sinks and fault flag
// assumes digitised comparator outputs synchronous to clk_sys; one clock domain
`timescale 1ns/10ps
module led_fault_supervisor
#(
    parameter int unsigned DIV_COUNT = fault_sup_pkg::sw_div,
    parameter int unsigned LOW_COUNT = fault_sup_pkg::low_cycles
)
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       dim_en,
    input  wire logic       input_uv,
    input  wire logic       overtemp,
    input  wire logic       current_set_over,
    input  wire logic       freq_set_over,
    input  wire logic       overvoltage_trip,
    input  wire logic       latch_event,
    input  wire logic       soft_start_done,
    input  wire logic [3:0] led_sink_pin_short,
    input  wire logic [3:0] led_sink_pin_open,
    input  wire logic [3:0] led_short_det,
    input  wire logic [3:0] in_regulation,
    output logic            boost_en,
    output logic            disconnect_on,
    output logic [3:0]      sink_en,
    output logic            fault_n,
    output logic            soft_start_en,
    output logic            vout_raise,
    output logic            shutdown
);

    fault_sup_pkg::sup_state_e state;
    fault_sup_pkg::sup_state_e next_state;

    logic       low_expired;
    logic       latched;
    logic [3:0] open_off;
    logic [3:0] short_off;
    logic       restart;
    logic       clear_all;
    logic       start_ok;
    logic       pins_clear;
    logic [3:0] open_new;

    // combined per-output permissions, each fault only ever takes away
    logic       next_boost;
    logic       next_disc;
    logic [3:0] next_sinks;
    logic       next_flag;

    // strings still allowed to carry current once removals are applied
    function automatic logic [fault_sup_pkg::n_strings-1:0] live_strings
    (
        input logic [fault_sup_pkg::n_strings-1:0] open_mask,
        input logic [fault_sup_pkg::n_strings-1:0] short_mask
    );
        return ~open_mask & ~short_mask;
    endfunction

    // a fresh start forgets every string removal of the last run
    function automatic logic restarting
    (
        input fault_sup_pkg::sup_state_e s
    );
        return s == fault_sup_pkg::st_pin_check;
    endfunction

    enable_low_timer
    #(
        .DIV_COUNT (DIV_COUNT),
        .LOW_COUNT (LOW_COUNT)
    )
    u_low_timer
    (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .dim_en      (dim_en),
        .low_expired (low_expired)
    );

    // conditions that send the device back through soft-start
    assign restart   = freq_set_over || overtemp;
    assign clear_all = input_uv || low_expired;

    // a start needs supply, enable and no latched fault pending
    assign start_ok   = !input_uv && !low_expired && dim_en && !latched;
    assign pins_clear = led_sink_pin_short == fault_sup_pkg::no_strings;
    // only strings not yet removed may start a new open search
    assign open_new   = led_sink_pin_open & live_strings(open_off, short_off);

    always_comb
    begin
        next_state = state;
        case (state)
            fault_sup_pkg::st_off:
            begin
                if (start_ok)
                    next_state = fault_sup_pkg::st_pin_check;
            end
            fault_sup_pkg::st_pin_check:
            begin
                // only moves on to soft-start once no pin reads shorted
                if (pins_clear && !restart)
                    next_state = fault_sup_pkg::st_soft_start;
            end
            fault_sup_pkg::st_soft_start:
            begin
                if (soft_start_done)
                    next_state = fault_sup_pkg::st_run;
            end
            fault_sup_pkg::st_run:
            begin
                if (open_new != fault_sup_pkg::no_strings)
                    next_state = fault_sup_pkg::st_open_seek;
            end
            fault_sup_pkg::st_open_seek:
            begin
                if (overvoltage_trip)
                    next_state = fault_sup_pkg::st_run;
            end
            default:
            begin
                next_state = fault_sup_pkg::st_off;
            end
        endcase
        if (restart && state != fault_sup_pkg::st_off)
            next_state = fault_sup_pkg::st_pin_check;
        if (clear_all || latched)
            next_state = fault_sup_pkg::st_off;
    end

    // sync reset only; every input already lives in this clock domain
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            state <= fault_sup_pkg::st_off;
        else
            state <= next_state;
    end

    // latched fault: a new event in the clearing cycle still sets it
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            latched <= 1'b0;
        else if (latch_event)
            latched <= 1'b1;
        else if (clear_all)
            latched <= 1'b0;
    end

    // strings found open stay off until the next start
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            open_off <= fault_sup_pkg::no_strings;
        else if (state == fault_sup_pkg::st_open_seek && overvoltage_trip)
            open_off <= open_off | ~in_regulation;
        else if (clear_all || restarting(state))
            open_off <= fault_sup_pkg::no_strings;
    end

    // shorted strings are removed; detection beats a same-cycle clear
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            short_off <= fault_sup_pkg::no_strings;
        else if (state != fault_sup_pkg::st_off && led_short_det != fault_sup_pkg::no_strings)
            short_off <= short_off | led_short_det;
        else if (clear_all || restarting(state))
            short_off <= fault_sup_pkg::no_strings;
    end

    always_comb
    begin
        next_boost = 1'b1;
        next_disc  = 1'b1;
        next_sinks = fault_sup_pkg::all_strings;
        next_flag  = 1'b0;
        case (state)
            fault_sup_pkg::st_off:
            begin
                next_boost = 1'b0;
                next_disc  = 1'b0;
                next_sinks = fault_sup_pkg::no_strings;
            end
            fault_sup_pkg::st_pin_check:
            begin
                // disconnect stays on so the pins can be checked
                next_boost = 1'b0;
                next_sinks = fault_sup_pkg::no_strings;
            end
            fault_sup_pkg::st_soft_start,
            fault_sup_pkg::st_run,
            fault_sup_pkg::st_open_seek:
            begin
                // a live short drops its string on the edge it is first seen
                next_sinks = live_strings(open_off, short_off) & ~led_short_det;
            end
            default:
            begin
                next_boost = 1'b0;
                next_disc  = 1'b0;
                next_sinks = fault_sup_pkg::no_strings;
            end
        endcase
        // dimming low gates the sinks but leaves boost to the analog loop
        if (!dim_en)
            next_sinks = fault_sup_pkg::no_strings;
        if (current_set_over)
        begin
            next_boost = 1'b0;
            next_sinks = fault_sup_pkg::no_strings;
        end
        if (freq_set_over)
        begin
            next_boost = 1'b0;
            next_disc  = 1'b0;
            next_sinks = fault_sup_pkg::no_strings;
            next_flag  = 1'b1;
        end
        if (overvoltage_trip)
            next_boost = 1'b0;
        if (overtemp || input_uv)
        begin
            next_boost = 1'b0;
            next_disc  = 1'b0;
            next_sinks = fault_sup_pkg::no_strings;
        end
        if (latched || latch_event)
        begin
            next_boost = 1'b0;
            next_disc  = 1'b0;
            next_sinks = fault_sup_pkg::no_strings;
        end
        // the flag drops on the clearing edge so it never outlives shutdown
        if ((latched && !clear_all) || latch_event)
            next_flag = 1'b1;
    end

    // registered so the stage never sees a decode glitch between fault inputs
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            boost_en <= 1'b0;
        else
            boost_en <= next_boost;
    end

    // the switch is off in st_off and for faults that must isolate the supply
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            disconnect_on <= 1'b0;
        else
            disconnect_on <= next_disc;
    end

    // per-string enables already carry dimming, removals and fault overrides
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sink_en <= fault_sup_pkg::no_strings;
        else
            sink_en <= next_sinks;
    end

    // active low so the pull-up reads no fault while the block sits in reset
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            fault_n <= 1'b1;
        else
            fault_n <= !next_flag;
    end

    // taken from the next state so the ramp starts with the state change
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            soft_start_en <= 1'b0;
        else
            soft_start_en <= next_state == fault_sup_pkg::st_soft_start;
    end

    // the target falls back on the edge that leaves the open search
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            vout_raise <= 1'b0;
        else
            vout_raise <= next_state == fault_sup_pkg::st_open_seek;
    end

    // a level that stays high until enable returns, not a pulse
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            shutdown <= 1'b0;
        else
            shutdown <= low_expired;
    end

endmodule

// File: rtl/fault_sup_pkg.sv
// constants and state codes for the led driver fault supervisor
// assumes all fault indications arrive already digitised and synchronous to clk_sys
// What this block does
// - startup pin short holds soft-start, no flag
// - short gone, soft-start released automatically
// - open pin raises output target until overvoltage
// - turn off unregulated strings, lower output again
// - current-set overcurrent stops boost and sinks, no flag
// - current-set fault gone, regulation resumes automatically
// - freq-set overcurrent flags, turns everything off
// - freq-set fault gone, restart through soft-start
// - overvoltage stops switching only, resumes when lower
// - led short removes only that string
// - overtemperature turns everything off, restarts automatically
// - input undervoltage turns off, clears latched faults
// - enable low long clears latch, high re-enables
// - long enable low clears faults, sinks off
package fault_sup_pkg;

    localparam int unsigned sys_clk_hz    = 250_000_000;
    localparam int unsigned sw_clk_hz     = 2_000_000;
    // switching clock derived as an enable from the system clock
    localparam int unsigned sw_div        = sys_clk_hz / sw_clk_hz;
    localparam int unsigned div_w         = 8;
    // enable low for this many switching clock cycles means shutdown
    localparam int unsigned low_cycles    = 32_750;
    localparam int unsigned low_w         = 15;
    localparam int unsigned n_strings     = 4;

    localparam logic [3:0] all_strings    = 4'hf;
    localparam logic [3:0] no_strings     = 4'h0;

    typedef enum logic [2:0]
    {
        st_off        = 3'b000,
        st_pin_check  = 3'b001,
        st_soft_start = 3'b010,
        st_run        = 3'b011,
        st_open_seek  = 3'b100
    } sup_state_e;

endpackage

// File: rtl/enable_low_timer.sv
// measures how long the dimming/enable input has stayed low
// assumes dim_en is synchronous to clk_sys; counts in switching clock cycles
`timescale 1ns/10ps
module enable_low_timer
#(
    parameter int unsigned DIV_COUNT = fault_sup_pkg::sw_div,
    parameter int unsigned LOW_COUNT = fault_sup_pkg::low_cycles
)
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic dim_en,
    output logic      low_expired
);

    logic [fault_sup_pkg::div_w-1:0] div_cnt;
    logic [fault_sup_pkg::low_w-1:0] low_cnt;
    logic                            sw_tick;

    // one-cycle enable at the switching rate
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || div_cnt == fault_sup_pkg::div_w'(DIV_COUNT - 1))
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    assign sw_tick = (div_cnt == fault_sup_pkg::div_w'(DIV_COUNT - 1));

    // counter saturates so expiry stays a level until enable returns
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || dim_en)
            low_cnt <= '0;
        else if (sw_tick && low_cnt != fault_sup_pkg::low_w'(LOW_COUNT))
            low_cnt <= low_cnt + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            low_expired <= 1'b0;
        else
            low_expired <= !dim_en && low_cnt == fault_sup_pkg::low_w'(LOW_COUNT);
    end

endmodule

// File: dv/led_fault_supervisor_props.sv
// port assertions for the led fault supervisor
// assumes one clock domain; bound onto every instance of the supervisor
`timescale 1ns/10ps
module led_fault_supervisor_props
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       overtemp,
    input wire logic       input_uv,
    input wire logic       current_set_over,
    input wire logic       freq_set_over,
    input wire logic       overvoltage_trip,
    input wire logic [3:0] led_short_det,
    input wire logic       boost_en,
    input wire logic       disconnect_on,
    input wire logic [3:0] sink_en,
    input wire logic       fault_n,
    input wire logic       shutdown
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire all_off = !boost_en && !disconnect_on && sink_en == 4'h0;
    property p_cs;
        current_set_over |=> !boost_en && sink_en == 4'h0;
    endproperty
    a_cs: assert property (p_cs) else $error("cs overcurrent left output on");
    property p_fs;
        freq_set_over |=> all_off && !fault_n;
    endproperty
    a_fs: assert property (p_fs) else $error("fs overcurrent wrong response");
    property p_ovp;
        overvoltage_trip |=> !boost_en;
    endproperty
    a_ovp: assert property (p_ovp) else $error("boost ran during overvoltage");
    property p_short;
        led_short_det != 4'h0 |=> (sink_en & $past(led_short_det)) == 4'h0;
    endproperty
    a_short: assert property (p_short) else $error("shorted string still on");
    property p_ot;
        overtemp |=> all_off;
    endproperty
    a_ot: assert property (p_ot) else $error("overtemperature left output on");
    property p_uv;
        input_uv |=> all_off;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage left output on");
    property p_shut;
        shutdown |-> sink_en == 4'h0 && fault_n;
    endproperty
    a_shut: assert property (p_shut) else $error("sinks or flag active in shutdown");
    property p_flag;
        !fault_n |-> all_off;
    endproperty
    a_flag: assert property (p_flag) else $error("flag set with output on");
endmodule

bind led_fault_supervisor led_fault_supervisor_props u_props (.*);

// File: dv/analog_stage_model.sv
// behavioural power stage: soft-start ramp, output rise and string regulation
// assumes the supervisor's outputs on clk_sys; open pins come from the bench
`timescale 1ns/10ps
module analog_stage_model
(
    input wire logic       clk_sys,
    input wire logic       soft_start_en,
    input wire logic       vout_raise,
    input wire logic [3:0] led_sink_pin_open,
    output logic           soft_start_done = 1'b0,
    output logic           ovp_model = 1'b0,
    output logic [3:0]     in_regulation
);
    logic [3:0] ramp = 4'h0;
    // an open string can never regulate, whatever the output voltage
    assign in_regulation = ~led_sink_pin_open;
    always @(posedge clk_sys)
    begin
        ramp <= (soft_start_en || vout_raise) ? ramp + 4'h1 : 4'h0;
        soft_start_done <= soft_start_en && ramp >= 4'h6;
        ovp_model <= vout_raise && ramp >= 4'h9;
    end
endmodule

// File: dv/led_fault_supervisor_tb.sv
// self-checking bench for the led fault supervisor with the stage model
// assumes shortened switching and shutdown counts through the parameters
`timescale 1ns/10ps
module led_fault_supervisor_tb;
    localparam int unsigned div_n = 4;
    localparam int unsigned low_n = 8;
    // fault order: ovp, current-set, freq-set, overtemp, undervoltage
    localparam logic [7:0] hit [0:4] = '{8'h6a, 8'h60, 8'h00, 8'h20, 8'h20};
    localparam logic [7:0] back [0:4] = '{8'hea, 8'hea, 8'hef, 8'hef, 8'hef};
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic       dim_en = 1'b0;
    logic       latch_event = 1'b0;
    logic [4:0] flt = 5'h00;
    logic [3:0] led_sink_pin_short = 4'h0;
    logic [3:0] led_sink_pin_open = 4'h0;
    logic [3:0] led_short_det = 4'h0;
    logic       soft_start_done, ovp_model, boost_en, disconnect_on, fault_n;
    logic       soft_start_en, vout_raise, shutdown;
    logic [3:0] sink_en, in_regulation;
    wire        input_uv, overtemp, freq_set_over, current_set_over, overvoltage_trip;
    wire [7:0]  st = {boost_en, disconnect_on, fault_n, shutdown, sink_en};
    int         checks = 0;
    int         miscompares = 0;
    assign {input_uv, overtemp, freq_set_over, current_set_over} = flt[4:1];
    assign overvoltage_trip = ovp_model | flt[0];
    always #2 clk_sys = ~clk_sys;
    led_fault_supervisor #(.DIV_COUNT(div_n), .LOW_COUNT(low_n)) dut (.*);
    analog_stage_model stage (.*);

    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // a wait that runs out is reported and ends the run
    task automatic wait_st(input logic [7:0] exp, input int lim);
        for (int i = 0; i < lim && st !== exp; i++)
            @(negedge clk_sys);
        chk("state", exp, st);
        if (st !== exp)
            complete_run();
    endtask

    task automatic t_start;
        led_sink_pin_short = 4'h2;
        dim_en = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk("held", 8'h60, st);
        chk("softstart", 8'h00, {7'h00, soft_start_en});
        led_sink_pin_short = 4'h0;
        wait_st(8'hef, 40);
        for (int i = 0; i < 20 && soft_start_en; i++)
            @(negedge clk_sys);
        chk("ramp done", 8'h00, {7'h00, soft_start_en});
        if (soft_start_en)
            complete_run();
    endtask

    task automatic t_open;
        led_sink_pin_open = 4'h4;
        repeat (2) @(negedge clk_sys);
        chk("raise", 8'h01, {7'h00, vout_raise});
        wait_st(8'heb, 40);
        chk("lowered", 8'h00, {7'h00, vout_raise});
        led_sink_pin_open = 4'h0;
        led_short_det = 4'h1;
        wait_st(8'hea, 4);
        led_short_det = 4'h0;
    endtask

    task automatic t_faults;
        for (int i = 0; i < 5; i++)
        begin
            flt = 5'h01 << i;
            repeat (2) @(negedge clk_sys);
            chk("fault", hit[i], st);
            flt = 5'h00;
            wait_st(back[i], 60);
        end
    endtask

    task automatic t_latch;
        latch_event = 1'b1;
        @(negedge clk_sys);
        latch_event = 1'b0;
        dim_en = 1'b0;
        repeat (low_n * div_n - 2) @(negedge clk_sys);
        chk("latched", 8'h00, st);
        wait_st(8'h30, 2 * div_n + 4);
        dim_en = 1'b1;
        wait_st(8'hef, 60);
        latch_event = 1'b1;
        @(negedge clk_sys);
        latch_event = 1'b0;
        flt = 5'h10;
        repeat (2) @(negedge clk_sys);
        flt = 5'h00;
        wait_st(8'hef, 60);
    endtask

    initial
    begin
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("reset", 8'h20, st);
        t_start();
        t_open();
        t_faults();
        t_latch();
        complete_run();
    end
endmodule
